// ### rtl/adc_serial_control_interface.sv
// serial control and data interface of an eight channel 12-bit converter
// assumes the host masters cs_n, sclk and din; comparator_hi comes from an
// analog model on clk and answers the dac_trial code of the previous cycle
//
// Contract
// - differential pairs chosen by low select bits
// - result framed by one leading, three trailing zeros
// - straight or twos complement, MSB first, falling
// - acquire during last three bits; sclk shifts
// - external strobe high one sclk after byte
// - external mode: one bit per falling edge
// - external mode: outputs float while chip deselected
// - internal conversion: strobe low at most 10us
// - internal result held, MSB after strobe rises
// - deselect blocks input, floats dout, strobe only in external mode
// - first high bit is start bit
// - conversion starts on falling edge after byte
// - new start only after result_bit_five shown
// - early start by chip select abandons conversion
// - control byte field layout, MSB first
// - polarity and input configuration bit meanings
// - two mode bits select power and clock
// - single ended channel number from select bits
`timescale 1ns/100ps
module adc_serial_control_interface
    import adc_serial_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic conversion_strobe,
    output logic conversion_strobe_oe,
    // analog front end
    input wire logic comparator_hi,
    output logic [11:0] dac_trial,
    output logic track,
    output logic [2:0] pos_channel,
    output logic [2:0] neg_channel,
    output logic neg_is_ground,
    output logic unipolar,
    output logic [1:0] power_mode
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] cs_sync_q;      // [0],[1] synchroniser, [2] history
    logic [2:0] sclk_sync_q;    // same layout
    logic [1:0] din_sync_q;     // two stages, aligned with sclk_sync_q[1]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 3'h7;
            sclk_sync_q <= 3'h0;
            din_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], cs_n};
            sclk_sync_q <= {sclk_sync_q[1:0], sclk};
            din_sync_q <= {din_sync_q[0], din};
        end
    end

    logic cs_hi;                // chip deselected
    logic cs_fall;              // chip select just went low
    logic sclk_rise;
    logic sclk_fall;
    logic din_s;
    assign cs_hi = cs_sync_q[1];
    assign cs_fall = !cs_sync_q[1] && cs_sync_q[2];
    assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
    assign sclk_fall = !sclk_sync_q[1] && sclk_sync_q[2];
    assign din_s = din_sync_q[1];

    // ------------------------------------------------------------
    // state and shared signals
    // ------------------------------------------------------------
    rx_state_t rx_q;            // input side: hunting or taking a byte
    conv_state_t conv_q;        // conversion side
    logic [6:0] shift_q;        // control bits taken so far, newest in lsb
    logic [3:0] bit_cnt_q;      // control bits taken so far
    logic [7:0] cfg_q;          // last complete control byte
    logic force_q;              // chip select fell: next high bit is a start
    logic [3:0] out_cnt_q;      // result bits shown on dout
    logic [7:0] step_cnt_q;     // internal clock divider
    logic ext_mode_q;           // clock mode of the current conversion
    logic dout_q;
    logic dout_oe_q;
    logic strobe_q;
    logic strobe_oe_q;
    logic track_q;
    logic [2:0] pos_q;
    logic [2:0] neg_q;
    logic neg_gnd_q;
    logic uni_q;
    logic [1:0] pm_q;

    logic rx_rise;              // rising sclk while selected
    logic start_ok;             // a high bit may open a control byte
    logic take_start;
    logic ctrl_done;            // eighth control bit arrives now
    logic abandon;
    logic ext_sel;              // clock mode chosen for the armed byte
    logic msb_flip;             // two's complement of the sign bit

    sar_if sif();
    sar_engine u_sar (
        .clk(clk),
        .rst_n(rst_n),
        .bus(sif.eng)
    );

    // shifting is blocked while deselected
    assign rx_rise = sclk_rise && !cs_hi;
    assign start_ok = (conv_q == CV_IDLE) || (out_cnt_q >= B5_SHOWN_CNT) || force_q;
    assign take_start = (rx_q == RX_HUNT) && rx_rise && din_s && start_ok;
    assign ctrl_done = (rx_q == RX_CTRL) && rx_rise && (bit_cnt_q == CTRL_LAST);
    // chip select forcing a start before result_bit_five kills the run
    assign abandon = cs_fall && (conv_q != CV_IDLE) && (out_cnt_q < B5_SHOWN_CNT);
    // power-down codes keep the clock mode last chosen
    assign ext_sel = cfg_q[CB_PM_HI] ? cfg_q[CB_PM_LO] : ext_mode_q;
    assign msb_flip = (out_cnt_q == 4'h0) && !uni_q;

    assign sif.comp = comparator_hi;
    assign sif.start = (conv_q == CV_ARM) && sclk_fall && !ctrl_done && !abandon;
    assign sif.step = ((conv_q == CV_EXT) && sclk_fall && !ctrl_done && !abandon)
        || ((conv_q == CV_INT) && (step_cnt_q == INT_STEP_LAST) && !abandon);

    // ------------------------------------------------------------
    // input side: start bit hunt and control byte
    // ------------------------------------------------------------
    // data taken on rising sclk only, msb first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= RX_HUNT;
            bit_cnt_q <= 4'h0;
            shift_q <= 7'h00;
        end else if (cs_fall) begin
            rx_q <= RX_HUNT; // a falling select alone never starts a conversion
            bit_cnt_q <= 4'h0;
        end else begin
            case (rx_q)
                RX_HUNT: begin
                    // leading zeros are ignored
                    if (take_start) begin
                        rx_q <= RX_CTRL;
                        bit_cnt_q <= 4'h1;
                        shift_q <= 7'h01;
                    end
                end
                RX_CTRL: begin
                    if (rx_rise) begin
                        shift_q <= {shift_q[5:0], din_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (ctrl_done) begin
                            rx_q <= RX_HUNT;
                        end
                    end
                end
                default: rx_q <= RX_HUNT;
            endcase
        end
    end

    // the force flag is set by chip select and beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_q <= 1'b0;
        end else if (cs_fall) begin
            force_q <= 1'b1;
        end else if (take_start) begin
            force_q <= 1'b0;
        end
    end

    // complete control byte, kept for the armed conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= 8'h00;
        end else if (ctrl_done) begin
            cfg_q <= {shift_q, din_s};
        end
    end

    // ------------------------------------------------------------
    // input mux and track/hold
    // ------------------------------------------------------------
    // positive input depends on select bits alone, so it is set a bit early;
    // the negative side waits for the input configuration bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= 3'h0;
            neg_q <= 3'h1;
            neg_gnd_q <= 1'b1;
            track_q <= 1'b0;
        end else if (cs_fall) begin
            track_q <= 1'b0;
        end else if ((rx_q == RX_CTRL) && rx_rise) begin
            if (bit_cnt_q == CNT_POS) begin
                // channel = mid*4 + lo*2 + hi in either configuration
                pos_q <= {shift_q[CB_SEL_MID - (CTRL_BITS - 4)],
                          shift_q[CB_SEL_LO - (CTRL_BITS - 4)],
                          shift_q[CB_SEL_HI - (CTRL_BITS - 4)]};
                track_q <= 1'b1; // acquire over the last three bits
            end
            if (bit_cnt_q == CNT_NEG) begin
                neg_gnd_q <= din_s; // 1 = single ended to ground
                // pair partner: hi = 0 puts the even channel positive
                neg_q <= {shift_q[CB_SEL_MID - (CTRL_BITS - 5)],
                          shift_q[CB_SEL_LO - (CTRL_BITS - 5)],
                          !shift_q[CB_SEL_HI - (CTRL_BITS - 5)]};
            end
            if (ctrl_done) begin
                track_q <= 1'b0; // hold from the eighth bit on
            end
        end
    end

    // ------------------------------------------------------------
    // conversion side
    // ------------------------------------------------------------
    // a fresh control byte always re-arms, which is what makes overlapped
    // bytes work; an early start by chip select abandons the run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_q <= CV_IDLE;
            out_cnt_q <= 4'h0;
            step_cnt_q <= 8'h00;
            ext_mode_q <= 1'b0;  // power-up in internal clock mode
            strobe_q <= 1'b1;
            dout_q <= 1'b0;
            uni_q <= 1'b0;
            pm_q <= PM_INT;
        end else if (ctrl_done) begin
            conv_q <= CV_ARM;
            out_cnt_q <= 4'h0;
        end else if (abandon) begin
            conv_q <= CV_IDLE;
            out_cnt_q <= 4'h0;
            strobe_q <= !ext_mode_q;
        end else begin
            if (cs_fall && ext_mode_q) begin
                strobe_q <= 1'b0; // driven low after select in external mode
            end
            case (conv_q)
                CV_IDLE: begin
                    if (sclk_fall) begin
                        dout_q <= 1'b0; // zeros after the last result bit
                    end
                end
                CV_ARM: begin
                    // start on the falling edge after the eighth bit
                    if (sclk_fall) begin
                        ext_mode_q <= ext_sel;
                        uni_q <= cfg_q[CB_POL];
                        pm_q <= cfg_q[CB_PM_HI:CB_PM_LO];
                        dout_q <= 1'b0; // leading zero of the result frame
                        step_cnt_q <= 8'h00;
                        if (ext_sel) begin
                            conv_q <= CV_EXT;
                            strobe_q <= 1'b1; // one sclk period high
                        end else begin
                            conv_q <= CV_INT;
                            strobe_q <= 1'b0; // low while converting
                        end
                    end
                end
                CV_EXT: begin
                    // each falling edge decides and shows one bit
                    if (sclk_fall) begin
                        strobe_q <= 1'b0;
                        dout_q <= comparator_hi ^ msb_flip;
                        out_cnt_q <= out_cnt_q + 4'h1;
                        if (out_cnt_q == RES_LAST) begin
                            conv_q <= CV_IDLE; // trailing zeros follow
                        end
                    end
                end
                CV_INT: begin
                    // own clock runs the decisions; sclk only shifts
                    if (sif.done) begin
                        conv_q <= CV_READ;
                        strobe_q <= 1'b1;
                    end else if (step_cnt_q == INT_STEP_LAST) begin
                        step_cnt_q <= 8'h00;
                    end else begin
                        step_cnt_q <= step_cnt_q + 8'h01;
                    end
                    if (sclk_fall) begin
                        dout_q <= 1'b0;
                    end
                end
                CV_READ: begin
                    // held result, msb on the first falling edge
                    if (sclk_fall) begin
                        dout_q <= sif.trial[RES_LAST - out_cnt_q] ^ msb_flip;
                        out_cnt_q <= out_cnt_q + 4'h1;
                        if (out_cnt_q == RES_LAST) begin
                            conv_q <= CV_IDLE;
                        end
                    end
                end
                default: conv_q <= CV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // output enables
    // ------------------------------------------------------------
    // dout floats when deselected; the strobe only in external mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_oe_q <= 1'b0;
            strobe_oe_q <= 1'b1;
        end else begin
            dout_oe_q <= !cs_hi;
            strobe_oe_q <= !(ext_mode_q && cs_hi);
        end
    end

    assign dout = dout_q;
    assign dout_oe = dout_oe_q;
    assign conversion_strobe = strobe_q;
    assign conversion_strobe_oe = strobe_oe_q;
    assign dac_trial = sif.trial;
    assign track = track_q;
    assign pos_channel = pos_q;
    assign neg_channel = neg_q;
    assign neg_is_ground = neg_gnd_q;
    assign unipolar = uni_q;
    assign power_mode = pm_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int LOW_MAX = STROBE_LOW_MAX_CYC;

    // cycles the internal strobe has been low; the bound is far too long
    // for a delay range, so it is counted here and checked below
    logic [11:0] low_cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= 12'h000;
        end else if (strobe_q || ext_mode_q) begin
            low_cnt_q <= 12'h000; // strobe high or external mode: nothing to time
        end else if (low_cnt_q != '1) begin
            low_cnt_q <= low_cnt_q + 12'h001; // saturates, so it never wraps to a pass
        end
    end

    strobe_rise_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
        (conv_q == CV_ARM) && sclk_fall && ext_sel && !ctrl_done && !abandon
        |=> strobe_q && (conv_q == CV_EXT))
        else $error("strobe not raised at external start");
    strobe_one_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        (conv_q == CV_EXT) && sclk_fall |=> !strobe_q)
        else $error("external strobe longer than one sclk period");
    ext_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        ext_mode_q && cs_hi ##1 ext_mode_q |-> !strobe_oe_q && !dout_oe_q)
        else $error("outputs driven while deselected in external mode");
    int_strobe_driven_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ext_mode_q ##1 !ext_mode_q |-> strobe_oe_q)
        else $error("strobe floated in internal mode");
    int_low_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        (conv_q == CV_INT) |-> (low_cnt_q < LOW_MAX))
        else $error("internal conversion strobe low too long");
    track_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(track_q) |-> (rx_q == RX_CTRL) && (bit_cnt_q == CNT_NEG))
        else $error("track opened at the wrong control bit");
    start_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_q == RX_HUNT) && rx_rise && !start_ok && !cs_fall |=> rx_q == RX_HUNT)
        else $error("start bit taken before result_bit_five shown");
    zero_hunt_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_q == RX_HUNT) && !din_s |=> rx_q == RX_HUNT)
        else $error("zero bit opened a control byte");
    read_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
        (conv_q == CV_READ) && sclk_fall && (out_cnt_q == 4'h0) && !ctrl_done && !abandon
        |=> dout_q == ($past(sif.trial[RES_LAST]) ^ !uni_q))
        else $error("internal result msb wrong");

    ext_run_c: cover property (@(posedge clk) disable iff (!rst_n)
        (conv_q == CV_EXT) && (out_cnt_q == RES_LAST) && sclk_fall);
    int_run_c: cover property (@(posedge clk) disable iff (!rst_n)
        (conv_q == CV_READ) && (out_cnt_q == RES_LAST) && sclk_fall);
    abandon_c: cover property (@(posedge clk) disable iff (!rst_n) abandon);
    overlap_c: cover property (@(posedge clk) disable iff (!rst_n)
        take_start && (conv_q != CV_IDLE));

endmodule // adc_serial_control_interface

// ### rtl/adc_serial_pkg.sv
// constants, field layout and state codes of the converter serial control block
// assumes a 200 MHz system clock and a host that masters the serial link
package adc_serial_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;                 // system clock rate
    localparam int INT_STEP_NS = 500;             // internal clock: one bit decision
    localparam int INT_STEP_CYC = (INT_STEP_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] INT_STEP_LAST = 8'(INT_STEP_CYC - 1);
    localparam int STROBE_LOW_MAX_NS = 10000;     // longest internal conversion
    localparam int STROBE_LOW_MAX_CYC = (STROBE_LOW_MAX_NS * CLK_MHZ) / 1000;

    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam int RES_BITS = 12;
    localparam int CTRL_BITS = 8;
    localparam logic [3:0] RES_LAST = 4'hb;       // index of the last result bit
    localparam logic [3:0] CTRL_LAST = 4'h7;      // bits held before the eighth
    localparam logic [3:0] B5_SHOWN_CNT = 4'h7;   // bits out once result_bit_five shown
    localparam logic [3:0] CNT_POS = 4'h4;        // bits held when positive input is set
    localparam logic [3:0] CNT_NEG = 4'h5;        // bits held when negative input is set
    localparam logic [RES_BITS-1:0] SAR_MSB_ONE = 12'h800;

    // ------------------------------------------------------------
    // control byte layout
    // ------------------------------------------------------------
    localparam int CB_SEL_HI = 6;                 // channel_select_hi
    localparam int CB_SEL_MID = 5;                // channel_select_mid
    localparam int CB_SEL_LO = 4;                 // channel_select_lo
    localparam int CB_POL = 3;                    // polarity_bit, 1 = unipolar
    localparam int CB_CFG = 2;                    // input_config_bit, 1 = single ended
    localparam int CB_PM_HI = 1;                  // power_clock_mode_hi
    localparam int CB_PM_LO = 0;                  // power_clock_mode_lo
    localparam logic [1:0] PM_INT = 2'h2;         // internal clock mode
    localparam logic [1:0] PM_EXT = 2'h3;         // external clock mode

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_HUNT = 2'h1,
        RX_CTRL = 2'h2
    } rx_state_t;

    typedef enum logic [4:0] {
        CV_IDLE = 5'h01,
        CV_ARM = 5'h02,
        CV_EXT = 5'h04,
        CV_INT = 5'h08,
        CV_READ = 5'h10
    } conv_state_t;

endpackage

// ### rtl/sar_engine.sv
// successive approximation register engine, one decision per step pulse
// assumes start and step come as one-cycle pulses on clk
`timescale 1ns/100ps
module sar_engine
    import adc_serial_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control side
    sar_if.eng bus
);

    logic [RES_BITS-1:0] trial_q;   // successive_approx_register
    logic [3:0] idx_q;              // bit now being decided
    logic done_q;                   // result complete

    // ------------------------------------------------------------
    // bit decisions
    // ------------------------------------------------------------
    // start wins over step so an abandoned conversion never leaks bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trial_q <= '0;
            idx_q <= RES_LAST;
            done_q <= 1'b0;
        end else if (bus.start) begin
            trial_q <= SAR_MSB_ONE;
            idx_q <= RES_LAST;
            done_q <= 1'b0;
        end else if (bus.step && !done_q) begin
            trial_q[idx_q] <= bus.comp;
            if (idx_q != 4'h0) begin
                trial_q[idx_q - 4'h1] <= 1'b1;
                idx_q <= idx_q - 4'h1;
            end else begin
                done_q <= 1'b1;
            end
        end
    end

    assign bus.trial = trial_q;
    assign bus.done = done_q;

endmodule // sar_engine

// ### rtl/sar_if.sv
// carrier between the serial control logic and the successive approximation engine
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface sar_if;
    logic start;                  // pulse: clear and load the first trial
    logic step;                   // pulse: take one bit decision
    logic comp;                   // comparator says input above trial
    logic [11:0] trial;           // trial code, final result when done
    logic done;                   // all bits decided

    modport ctl (output start, output step, output comp, input trial, input done);
    modport eng (input start, input step, input comp, output trial, output done);
endinterface

// ### verif/host_model.sv
// host side serial master: chip select, serial clock and data, captures dout
// assumes clk is the device clock; every pin change lands on its falling edge
`timescale 1ns/100ps
module host_model (
    // timing reference
    input wire logic clk,
    // serial link
    output logic cs_n,
    output logic sclk,
    input wire logic dout,
    output logic din
);
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // wait n falling edges of clk
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask
    // chip select change, then settle time for the pin synchronisers
    task automatic sel(input logic v);
        cs_n = v;
        gap(4);
    endtask
    // one byte out msb first and one in, 80 ns clock, rising edge samples
    // the low phase before each of the last three rising edges is stretched so
    // the acquisition window lasts at least 1.5us
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din = tx[i];
            gap(i < 3 ? 108 : 8);
            sclk = 1'b1;
            rx[i] = dout;
            gap(8);
            sclk = 1'b0;
        end
    endtask
endmodule // host_model

// ### verif/tb_adc_serial_control_interface.sv
// testbench: host model on the link, comparator model on the analog side
// assumes the converter answers comparator_hi one cycle after dac_trial
`timescale 1ns/100ps
module tb_adc_serial_control_interface;
    import adc_serial_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, din, dout, dout_oe, strb, strb_oe, track, gnd, uni;
    logic cmp = 1'b0; // comparator answer, offset binary
    logic [11:0] vin = 12'h5a3; // fixed input level
    logic [11:0] trial;
    logic [2:0] pos, neg;
    logic [1:0] pm;
    logic [7:0] hi, lo;
    // sclk is fast enough for external mode
    logic [7:0] ctl [4] = '{8'hef, 8'hd3, 8'h86, 8'hf8}; // ext, ext, int, power-down
    logic [9:0] mux [4] = '{10'h28f, 10'h1a3, 10'h00a, 10'h3e4}; // pos,neg,gnd,uni,pm
    int num_errors = 0;
    int num_checks = 0;
    int n;
    int track_cycles = 0; // clk cycles seen with track high
    wire dout_pin; // dout as the host sees it: inverted when not driven
    assign dout_pin = dout_oe ? dout : ~dout;
    always #2.5 clk = ~clk;
    always @(posedge clk) track_cycles <= track_cycles + int'(track);
    // comparator sees the trial of the previous cycle
    always @(negedge clk) cmp <= (vin >= trial);
    host_model host_model_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .dout(dout_pin), .din(din));
    adc_serial_control_interface adc_serial_control_interface_inst (.clk(clk), .rst_n(rst_n),
        .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .conversion_strobe(strb), .conversion_strobe_oe(strb_oe), .comparator_hi(cmp),
        .dac_trial(trial), .track(track), .pos_channel(pos), .neg_channel(neg),
        .neg_is_ground(gnd), .unipolar(uni), .power_mode(pm));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts, verdict, end of run
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence: one full conversion per control byte
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        host_model_inst.gap(4);
        for (int k = 0; k < 4; k++) begin
            host_model_inst.sel(1'b0);
            repeat (2) host_model_inst.xfer(8'h00, hi); // 16 leading zeros ignored
            n = track_cycles;
            host_model_inst.xfer(ctl[k], hi);
            host_model_inst.gap(4);
            check(16'(strb), 16'(ctl[k][0]));
            check(16'(track_cycles - n), 16'h015c); // tracks over the last three bits
            n = 0;
            // sclk stays parked low while the strobe is low
            while (strb !== 1'b1) begin
                host_model_inst.gap(1);
                n++;
                if (n > 2100) begin
                    num_errors++;
                    tally_and_finish();
                end
            end
            check(16'(n <= 2000), 16'h0001); // strobe low phase bounded
            host_model_inst.xfer(8'h00, hi); // result read well inside 120us
            host_model_inst.xfer(8'h00, lo);
            // both modes: one zero ahead of the msb, three zeros after the lsb
            check({hi, lo},
                {1'b0, ctl[k][3] ? vin : vin ^ 12'h800, 3'h0});
            check(16'({pos, neg & {3{~ctl[k][2]}}, gnd, uni, pm}), 16'(mux[k]));
            host_model_inst.sel(1'b1);
            check({dout_oe, strb_oe}, {14'h0, 1'b0, ~ctl[k][0]});
        end
        tally_and_finish();
    end
endmodule // tb_adc_serial_control_interface
